// >>> src/cpwm_pkg.sv
// constants of the complementary pwm output stage
package cpwm_pkg;
  localparam int CPWM_ADDR_W = 4;
  localparam int CPWM_DATA_W = 16;
  localparam int CPWM_CHANS  = 6;
  localparam int CPWM_PAIRS  = 3;
  localparam int CPWM_DT_W   = 8;

  // register indices
  localparam logic [3:0] CPWM_REG_CTRL   = 4'h0;
  localparam logic [3:0] CPWM_REG_POL    = 4'h1;
  localparam logic [3:0] CPWM_REG_OVR    = 4'h2;
  localparam logic [3:0] CPWM_REG_DEAD   = 4'h3;
  localparam logic [3:0] CPWM_REG_VAL1   = 4'h4;
  localparam logic [3:0] CPWM_REG_VAL6   = 4'h9;
  localparam logic [3:0] CPWM_REG_STATUS = 4'ha;

  // control register fields
  localparam int CPWM_CTRL_EN_BIT    = 0;
  localparam int CPWM_CTRL_INDEPENDENT_MODE_OPTION_BIT = 1;
  localparam int CPWM_CTRL_MLO_BIT   = 2;
  localparam int CPWM_CTRL_MHI_BIT   = 3;
  localparam int CPWM_CTRL_OVR_BIT   = 4;

  // status register fields
  localparam int CPWM_ST_ACT_LSB  = 0;
  localparam int CPWM_ST_SNS_LSB  = 3;
  localparam int CPWM_ST_PWM_LSB  = 6;
  localparam int CPWM_ST_OVR_BIT  = 12;

  // values after reset
  localparam logic [7:0]  CPWM_DEAD_RST  = 8'hff;
  localparam logic [15:0] CPWM_VAL_RST   = 16'h0000;
  localparam logic [2:0]  CPWM_POL_RST   = 3'h0;
  localparam logic [5:0]  CPWM_OVR_RST   = 6'h00;

  // correction method codes
  localparam logic [1:0] CPWM_METH_DEADTIME = 2'h2;
  localparam logic [1:0] CPWM_METH_HALFEND  = 2'h3;
endpackage

// >>> src/cpwm_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module cpwm_sync2 #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      pin_sync <= '0;
    end else begin
      stage1   <= pin_async;
      pin_sync <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> src/cpwm_dead_time.sv
// dead-time generator for one complementary pair
`timescale 1ns/100ps
`default_nettype none
module cpwm_dead_time
  import cpwm_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  top_src,
  input  wire logic                  bottom_allow,
  input  wire logic [CPWM_DT_W-1:0]  dead_time_setting,
  output logic                       top_drive,
  output logic                       bottom_drive
);
  logic                 top_prev;
  logic [CPWM_DT_W-1:0] dead_count;
  logic                 src_edge;
  logic                 force_off;
  logic                 dt_nonzero;

  assign src_edge   = top_src ^ top_prev;
  assign dt_nonzero = dead_time_setting != '0;
  assign force_off  = (src_edge && dt_nonzero) || (dead_count != '0);
  // bottom is inverse top, gated by dead time
  assign top_drive    = top_src && !force_off;
  assign bottom_drive = !top_src && !force_off && bottom_allow;

  // reload on edge, count down each cpu clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      top_prev   <= 1'b0;
      dead_count <= '0;
    end else begin
      top_prev <= top_src;
      if (src_edge && dt_nonzero) begin
        dead_count <= dead_time_setting - 8'h01;
      end else if (dead_count != '0) begin
        dead_count <= dead_count - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/cpwm_output_stage.sv
// complementary pwm output stage: mode, dead time, top/bottom selection
`timescale 1ns/100ps
`default_nettype none
module cpwm_output_stage (
  input  wire logic                                  clk_sys,
  input  wire logic                                  reset_n,
  input  wire logic [cpwm_pkg::CPWM_ADDR_W-1:0]      reg_addr,
  input  wire logic [cpwm_pkg::CPWM_DATA_W-1:0]      reg_wdata,
  input  wire logic                                  reg_write,
  input  wire logic                                  reg_read,
  output logic      [cpwm_pkg::CPWM_DATA_W-1:0]      reg_rdata,
  input  wire logic [cpwm_pkg::CPWM_CHANS-1:0]       gen_pwm,
  input  wire logic                                  cycle_start,
  input  wire logic                                  half_cycle,
  input  wire logic                                  center_aligned_mode,
  input  wire logic [cpwm_pkg::CPWM_PAIRS-1:0]       phase_current_sense_pins,
  output logic      [cpwm_pkg::CPWM_CHANS*16-1:0]    chan_compare,
  output logic      [cpwm_pkg::CPWM_CHANS-1:0]       pwm_out
);
  import cpwm_pkg::*;

  // software-visible control state
  logic                   generator_enable;
  logic                   independent_mode_option;
  logic                   correction_method_hi;
  logic                   correction_method_lo;
  logic                   output_override_enable;
  logic [CPWM_PAIRS-1:0]  phase_polarity_bits;
  logic [CPWM_CHANS-1:0]  output_override_bits;
  logic [CPWM_DT_W-1:0]   dead_time_setting;
  logic [CPWM_DATA_W-1:0] value_reg [CPWM_CHANS];

  // internal state
  logic                   enable_prev;
  logic                   override_active;
  logic [CPWM_PAIRS-1:0]  sensed_polarity;
  logic [CPWM_PAIRS-1:0]  active_polarity;
  logic [CPWM_PAIRS-1:0]  sense_sync;

  // helper: is the address one of the six value registers
  function automatic logic is_value_addr(input logic [3:0] a);
    is_value_addr = (a >= CPWM_REG_VAL1) && (a <= CPWM_REG_VAL6);
  endfunction

  // helper: pick the compare value for one pair
  function automatic logic [15:0] pick_value(input logic        pol,
                                             input logic [15:0] odd_v,
                                             input logic [15:0] even_v);
    pick_value = pol ? even_v : odd_v;
  endfunction

  // address decode
  logic       wr_ctrl;
  logic       wr_pol;
  logic       wr_ovr;
  logic       wr_dead;
  logic       wr_value;
  logic [3:0] addr_off;
  logic [2:0] value_idx;

  assign wr_ctrl   = reg_write && (reg_addr == CPWM_REG_CTRL);
  assign wr_pol    = reg_write && (reg_addr == CPWM_REG_POL);
  assign wr_ovr    = reg_write && (reg_addr == CPWM_REG_OVR);
  assign wr_dead   = reg_write && (reg_addr == CPWM_REG_DEAD);
  assign wr_value  = reg_write && is_value_addr(reg_addr);
  assign addr_off  = reg_addr - CPWM_REG_VAL1;
  assign value_idx = addr_off[2:0];

  // control register writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      generator_enable        <= 1'b0;
      independent_mode_option <= 1'b0;
      correction_method_hi    <= 1'b0;
      correction_method_lo    <= 1'b0;
      output_override_enable  <= 1'b0;
    end else if (wr_ctrl) begin
      generator_enable        <= reg_wdata[CPWM_CTRL_EN_BIT];
      independent_mode_option <= reg_wdata[CPWM_CTRL_INDEPENDENT_MODE_OPTION_BIT];
      correction_method_hi    <= reg_wdata[CPWM_CTRL_MHI_BIT];
      correction_method_lo    <= reg_wdata[CPWM_CTRL_MLO_BIT];
      output_override_enable  <= reg_wdata[CPWM_CTRL_OVR_BIT];
    end
  end

  // polarity, override and dead-time settings
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_polarity_bits  <= CPWM_POL_RST;
      output_override_bits <= CPWM_OVR_RST;
      // 8-bit dead time, cpu clock units
      dead_time_setting    <= CPWM_DEAD_RST;
    end else begin
      if (wr_pol) begin
        phase_polarity_bits <= reg_wdata[CPWM_PAIRS-1:0];
      end
      if (wr_ovr) begin
        output_override_bits <= reg_wdata[CPWM_CHANS-1:0];
      end
      if (wr_dead) begin
        dead_time_setting <= reg_wdata[CPWM_DT_W-1:0];
      end
    end
  end

  // compare value registers, one per channel
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CPWM_CHANS; i++) begin
        value_reg[i] <= CPWM_VAL_RST;
      end
    end else if (wr_value) begin
      value_reg[value_idx] <= reg_wdata;
    end
  end

  // sense pins come from outside the clock domain
  cpwm_sync2 #(
    .WIDTH (CPWM_PAIRS)
  ) u_sense_sync (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_async (phase_current_sense_pins),
    .pin_sync  (sense_sync)
  );

  // correction method decode
  logic       method_software;
  logic       method_deadtime;
  logic       method_halfend;
  logic       enable_rise;
  logic       halfend_strobe;

  assign method_software = !correction_method_hi;
  assign method_deadtime = {correction_method_hi, correction_method_lo}
                           == CPWM_METH_DEADTIME;
  assign method_halfend  = {correction_method_hi, correction_method_lo}
                           == CPWM_METH_HALFEND;
  assign enable_rise     = generator_enable && !enable_prev;
  // center: mid-cycle, edge: end of cycle
  assign halfend_strobe  = center_aligned_mode ? half_cycle : cycle_start;

  // sense latch conditions per pair
  logic [CPWM_PAIRS-1:0] pair_off;
  logic [CPWM_PAIRS-1:0] sense_take;

  generate
    for (genvar k = 0; k < CPWM_PAIRS; k++) begin : g_sense
      // no sampling in independent mode, where no pair exists
      assign pair_off[k] = !pwm_out[2*k] && !pwm_out[2*k+1];
      // latch while both pair outputs are off (method 10) or on the half/end strobe (method 11)
      assign sense_take[k] = generator_enable && !independent_mode_option
                             && ((method_deadtime && pair_off[k])
                                 || (method_halfend && halfend_strobe));
    end
  endgenerate

  // latched sense values; a new sample beats the enable-time clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sensed_polarity <= '0;
      enable_prev     <= 1'b0;
    end else begin
      enable_prev <= generator_enable;
      for (int k = 0; k < CPWM_PAIRS; k++) begin
        if (sense_take[k]) begin
          sensed_polarity[k] <= sense_sync[k];
        end else if (enable_rise) begin
          sensed_polarity[k] <= 1'b0;
        end
      end
    end
  end

  // polarity source for the coming period
  logic [CPWM_PAIRS-1:0] next_polarity;

  // software bits for method 00 and 01
  assign next_polarity = method_software ? phase_polarity_bits
                                         : sensed_polarity;

  // polarity changes at the period boundary or when the generator is enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      active_polarity <= '0;
    end else if (enable_rise) begin
      // first period uses registers 1, 3 and 5 for methods 10 and 11, the software bits for 00 and 01
      active_polarity <= method_software ? phase_polarity_bits : '0;
    end else if (cycle_start) begin
      // selection made at each period start
      active_polarity <= next_polarity;
    end
  end

  // override takes hold at once, releases only at a cycle start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      override_active <= 1'b0;
    end else if (output_override_enable) begin
      override_active <= 1'b1;
    end else if (cycle_start) begin
      override_active <= 1'b0;
    end
  end

  // compare value per channel
  logic [CPWM_CHANS*16-1:0] next_compare;

  generate
    for (genvar k = 0; k < CPWM_PAIRS; k++) begin : g_compare
      logic [15:0] pair_value;
      // polarity 0 odd register, 1 even
      assign pair_value = pick_value(active_polarity[k], value_reg[2*k],
                                     value_reg[2*k+1]);
      // pair shares one value; independent uses its own
      assign next_compare[32*k+15 -: 16] = independent_mode_option
                                           ? value_reg[2*k] : pair_value;
      assign next_compare[32*k+31 -: 16] = independent_mode_option
                                           ? value_reg[2*k+1] : pair_value;
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_compare <= '0;
    end else begin
      chan_compare <= next_compare;
    end
  end

  // dead-time generators, one per pair
  logic [CPWM_PAIRS-1:0] top_src;
  logic [CPWM_PAIRS-1:0] bottom_allow;
  logic [CPWM_PAIRS-1:0] top_drive;
  logic [CPWM_PAIRS-1:0] bottom_drive;

  generate
    for (genvar k = 0; k < CPWM_PAIRS; k++) begin : g_dead
      // odd override bit replaces generator top
      assign top_src[k] = override_active ? output_override_bits[2*k]
                                          : gen_pwm[2*k];
      // even bit: complement or held inactive
      assign bottom_allow[k] = override_active
                               ? output_override_bits[2*k+1] : 1'b1;

      cpwm_dead_time u_dead (
        .clk_sys           (clk_sys),
        .reset_n           (reset_n),
        .top_src           (top_src[k]),
        .bottom_allow      (bottom_allow[k]),
        .dead_time_setting (dead_time_setting),
        .top_drive         (top_drive[k]),
        .bottom_drive      (bottom_drive[k])
      );
    end
  endgenerate

  // output selection
  logic [CPWM_CHANS-1:0] comp_out;
  logic [CPWM_CHANS-1:0] independent_mode_option_out;
  logic [CPWM_CHANS-1:0] next_pwm;
  logic                  drive_allowed;

  generate
    for (genvar k = 0; k < CPWM_PAIRS; k++) begin : g_pair_out
      // override through dead time in pairs
      assign comp_out[2*k]   = top_drive[k];
      assign comp_out[2*k+1] = bottom_drive[k];
    end
  endgenerate

  assign independent_mode_option_out     = override_active ? output_override_bits : gen_pwm;
  // override drives the pins even while the generator is off
  assign drive_allowed = generator_enable || override_active;
  assign next_pwm      = !drive_allowed ? '0
                         : independent_mode_option ? independent_mode_option_out : comp_out;

  // registered so decode glitches never reach the gate drivers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_out <= '0;
    end else begin
      pwm_out <= next_pwm;
    end
  end

  // status word and read mux
  logic [CPWM_DATA_W-1:0] status_word;
  logic [CPWM_DATA_W-1:0] ctrl_word;
  logic [CPWM_DATA_W-1:0] value_word;
  logic [CPWM_DATA_W-1:0] next_rdata;

  always_comb begin
    status_word = '0;
    status_word[CPWM_ST_ACT_LSB +: CPWM_PAIRS] = active_polarity;
    status_word[CPWM_ST_SNS_LSB +: CPWM_PAIRS] = sensed_polarity;
    status_word[CPWM_ST_PWM_LSB +: CPWM_CHANS] = pwm_out;
    status_word[CPWM_ST_OVR_BIT]               = override_active;
    ctrl_word = '0;
    ctrl_word[CPWM_CTRL_EN_BIT]    = generator_enable;
    ctrl_word[CPWM_CTRL_INDEPENDENT_MODE_OPTION_BIT] = independent_mode_option;
    ctrl_word[CPWM_CTRL_MLO_BIT]   = correction_method_lo;
    ctrl_word[CPWM_CTRL_MHI_BIT]   = correction_method_hi;
    ctrl_word[CPWM_CTRL_OVR_BIT]   = output_override_enable;
  end

  // read decode; unmapped indices read as zero
  logic                   rd_ctrl;
  logic                   rd_pol;
  logic                   rd_ovr;
  logic                   rd_dead;
  logic                   rd_value;
  logic                   rd_status;

  assign rd_ctrl    = reg_addr == CPWM_REG_CTRL;
  assign rd_pol     = reg_addr == CPWM_REG_POL;
  assign rd_ovr     = reg_addr == CPWM_REG_OVR;
  assign rd_dead    = reg_addr == CPWM_REG_DEAD;
  assign rd_value   = is_value_addr(reg_addr);
  assign rd_status  = reg_addr == CPWM_REG_STATUS;
  assign value_word = value_reg[value_idx];
  assign next_rdata = rd_ctrl   ? ctrl_word :
                      rd_pol    ? {13'h0000, phase_polarity_bits} :
                      rd_ovr    ? {10'h000, output_override_bits} :
                      rd_dead   ? {8'h00, dead_time_setting} :
                      rd_value  ? value_word :
                      rd_status ? status_word : 16'h0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : '0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/cpwm_stage_asserts.sv
// assertions on the ports of the pwm output stage
`timescale 1ns/100ps
`default_nettype none
module cpwm_stage_chk (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [5:0]  gen_pwm,
  input wire logic        cycle_start,
  input wire logic        half_cycle,
  input wire logic        center_aligned_mode,
  input wire logic [2:0]  phase_current_sense_pins,
  input wire logic [95:0] chan_compare,
  input wire logic [5:0]  pwm_out
);
  import cpwm_pkg::*;
  logic [4:0]       ctrl;
  logic [7:0]       dead;
  logic [5:0]       ovr;
  logic [5:0][15:0] val;
  wire logic comp_run  = (ctrl == 5'h01);
  wire logic independent_mode_option_run = (ctrl == 5'h03);
  wire logic val_hit   = reg_addr >= CPWM_REG_VAL1
                         && reg_addr <= CPWM_REG_VAL6;
  // shadows of the written registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= 5'h00;
      dead <= CPWM_DEAD_RST;
      ovr  <= CPWM_OVR_RST;
      val  <= '0;
    end else if (reg_write) begin
      if (reg_addr == CPWM_REG_CTRL) ctrl <= reg_wdata[4:0];
      if (reg_addr == CPWM_REG_DEAD) dead <= reg_wdata[7:0];
      if (reg_addr == CPWM_REG_OVR) ovr <= reg_wdata[5:0];
      if (val_hit) val[reg_addr - CPWM_REG_VAL1] <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_dead_read: assert property (
    reg_read && reg_addr == CPWM_REG_DEAD |=> reg_rdata == {8'h00, dead})
    else $error("dead time readback wrong");
  a_unmapped_read: assert property (
    reg_read && reg_addr > CPWM_REG_STATUS |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_pair_exclusive: assert property (
    !ctrl[1] && !$past(ctrl[1]) && !$past(ctrl[1], 2)
    |-> !(pwm_out[0] && pwm_out[1]) && !(pwm_out[2] && pwm_out[3])
        && !(pwm_out[4] && pwm_out[5]))
    else $error("pair outputs active together");
  a_dead_gap: assert property (
    comp_run && $past(comp_run) && dead == 8'h02 && $changed(gen_pwm[0])
    |=> (pwm_out[1:0] == 2'b00) [*2]
        ##1 pwm_out[1:0] == {~gen_pwm[0], gen_pwm[0]})
    else $error("dead time gap wrong");
  a_zero_dead: assert property (
    comp_run && $past(comp_run) && dead == 8'h00 && $changed(gen_pwm[0])
    |=> pwm_out[1:0] == {~$past(gen_pwm[0]), $past(gen_pwm[0])})
    else $error("zero dead time inserted a gap");
  a_independent_mode_option_follow: assert property (
    independent_mode_option_run && $past(independent_mode_option_run) |=> pwm_out == $past(gen_pwm))
    else $error("independent output not following");
  a_independent_mode_option_values: assert property (
    ctrl[1] && $past(ctrl[1]) |-> chan_compare == $past(val))
    else $error("independent compare value wrong");
  a_ovr_pair: assert property (
    (ctrl[4] && !ctrl[1] && dead == 8'h02 && $stable(ovr)) [*6]
    |-> pwm_out[1:0] == {ovr[1] & ~ovr[0], ovr[0]})
    else $error("override pair output wrong");
  c_dead_gap: cover property (comp_run && $changed(gen_pwm[0]));
  c_override: cover property (ctrl[4] && pwm_out[1]);
  c_independent_mode_option: cover property (independent_mode_option_run && pwm_out[0] && pwm_out[1]);
endmodule
bind cpwm_output_stage cpwm_stage_chk u_chk (
  .clk_sys                  (clk_sys),
  .reset_n                  (reset_n),
  .reg_addr                 (reg_addr),
  .reg_wdata                (reg_wdata),
  .reg_write                (reg_write),
  .reg_read                 (reg_read),
  .reg_rdata                (reg_rdata),
  .gen_pwm                  (gen_pwm),
  .cycle_start              (cycle_start),
  .half_cycle               (half_cycle),
  .center_aligned_mode      (center_aligned_mode),
  .phase_current_sense_pins (phase_current_sense_pins),
  .chan_compare             (chan_compare),
  .pwm_out                  (pwm_out)
);
`default_nettype wire

// >>> bench/cpwm_gate_model.sv
// gate driver and phase current sense model
`timescale 1ns/100ps
`default_nettype none
module cpwm_gate_model (
  input  wire logic       clk_sys,
  input  wire logic [5:0] gate_in,
  input  wire logic [2:0] current_negative,
  input  wire logic       pair_mode,
  output logic      [2:0] sense_pins,
  output logic      [7:0] overlap_count
);
  // sense pin is high for negative phase current
  assign sense_pins = current_negative;
  // both gates on short the bus
  wire logic shoot = pair_mode && ((gate_in[0] && gate_in[1])
    || (gate_in[2] && gate_in[3]) || (gate_in[4] && gate_in[5]));
  initial overlap_count = 8'h00;
  always @(posedge clk_sys) begin
    if (shoot) overlap_count <= overlap_count + 8'h01;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the pwm output stage
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module testbench;
  import cpwm_pkg::*;
  logic        clk_sys;
  logic        reset_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic [5:0]  gen_pwm;
  logic        cycle_start;
  logic        half_cycle;
  logic        center_aligned_mode;
  logic [2:0]  sense;
  logic [95:0] chan_compare;
  logic [5:0]  pwm_out;
  logic [2:0]  cur_neg;
  logic        comp_mode;
  logic [7:0]  overlap_count;
  logic [15:0] vals [6];
  logic [2:0]  pol;
  logic [95:0] independent_mode_option_exp;
  int          err_count;
  int          tests_run;
  cpwm_output_stage u_dut (
    .clk_sys                  (clk_sys),
    .reset_n                  (reset_n),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_write                (reg_write),
    .reg_read                 (reg_read),
    .reg_rdata                (reg_rdata),
    .gen_pwm                  (gen_pwm),
    .cycle_start              (cycle_start),
    .half_cycle               (half_cycle),
    .center_aligned_mode      (center_aligned_mode),
    .phase_current_sense_pins (sense),
    .chan_compare             (chan_compare),
    .pwm_out                  (pwm_out)
  );
  cpwm_gate_model u_gates (
    .clk_sys          (clk_sys),
    .gate_in          (pwm_out),
    .current_negative (cur_neg),
    .pair_mode        (comp_mode),
    .sense_pins       (sense),
    .overlap_count    (overlap_count)
  );
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [95:0] exp_cmp(input logic [2:0] p);
    logic [95:0] r;
    for (int k = 0; k < 3; k++) begin
      r[32*k +: 16] = vals[2*k + int'(p[k])];
      r[32*k+16 +: 16] = vals[2*k + int'(p[k])];
    end
    return r;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    `CHK(reg_rdata, e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic pulse_start;
    @(posedge clk_sys);
    cycle_start <= 1'b1;
    @(posedge clk_sys);
    cycle_start <= 1'b0;
  endtask
  // compare values land one cycle after the polarity changes
  task automatic chk_cmp(input logic [2:0] p);
    tick(1);
    `CHK(chan_compare, exp_cmp(p))
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_of_test;
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    gen_pwm = 6'h00;
    cycle_start = 1'b0;
    half_cycle = 1'b0;
    center_aligned_mode = 1'b0;
    cur_neg = 3'h0;
    comp_mode = 1'b1;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(CPWM_REG_DEAD, 16'h00ff);
    rd(4'hb, 16'h0000);
    wr(4'hb, 16'h5a5a);
    rd(4'hb, 16'h0000);
    `CHK(pwm_out, 6'h00)
    for (int k = 0; k < 6; k++) begin
      vals[k] = 16'h1000 + 16'(k);
      wr(CPWM_REG_VAL1 + 4'(k), vals[k]);
    end
    $display("test registers done");
    wr(CPWM_REG_DEAD, 16'h0002);
    gen_pwm <= 6'h3f;
    rd(CPWM_REG_DEAD, 16'h0002);
    wr(CPWM_REG_CTRL, 16'h0001);
    tick(8);
    `CHK(pwm_out, 6'h15)
    @(posedge clk_sys);
    gen_pwm <= 6'h00;
    for (int i = 0; i < 3; i++) begin
      tick(1);
      `CHK(pwm_out, (i < 2) ? 6'h00 : 6'h2a)
    end
    wr(CPWM_REG_DEAD, 16'h0000);
    @(posedge clk_sys);
    gen_pwm <= 6'h15;
    tick(1);
    `CHK(pwm_out, 6'h15)
    $display("test dead time done");
    for (int m = 0; m < 2; m++) begin
      pol = (m == 0) ? 3'h5 : 3'h2;
      wr(CPWM_REG_CTRL, (m == 0) ? 16'h0001 : 16'h0005);
      wr(CPWM_REG_POL, {13'h0000, pol});
      chk_cmp((m == 0) ? 3'h0 : 3'h5);
      pulse_start;
      chk_cmp(pol);
    end
    cur_neg <= 3'h6;
    wr(CPWM_REG_CTRL, 16'h000d);
    pulse_start;
    pulse_start;
    chk_cmp(3'h6);
    @(posedge clk_sys);
    center_aligned_mode <= 1'b1;
    cur_neg <= 3'h3;
    tick(4);
    @(posedge clk_sys);
    half_cycle <= 1'b1;
    @(posedge clk_sys);
    half_cycle <= 1'b0;
    cur_neg <= 3'h6;
    pulse_start;
    chk_cmp(3'h3);
    $display("test polarity selection done");
    @(posedge clk_sys);
    center_aligned_mode <= 1'b0;
    cur_neg <= 3'h5;
    wr(CPWM_REG_DEAD, 16'h0004);
    wr(CPWM_REG_CTRL, 16'h0009);
    @(posedge clk_sys);
    gen_pwm <= 6'h00;
    tick(8);
    pulse_start;
    chk_cmp(3'h5);
    cur_neg <= 3'h2;
    tick(8);
    pulse_start;
    chk_cmp(3'h5);
    wr(CPWM_REG_CTRL, 16'h0000);
    wr(CPWM_REG_CTRL, 16'h0009);
    tick(1);
    chk_cmp(3'h0);
    $display("test pin sensing done");
    wr(CPWM_REG_DEAD, 16'h0002);
    wr(CPWM_REG_OVR, 16'h0001);
    wr(CPWM_REG_CTRL, 16'h0019);
    tick(8);
    `CHK(pwm_out, 6'h01)
    wr(CPWM_REG_OVR, 16'h0002);
    tick(8);
    `CHK(pwm_out, 6'h02)
    rd(CPWM_REG_STATUS, 16'h1090);
    wr(CPWM_REG_CTRL, 16'h0009);
    tick(4);
    `CHK(pwm_out, 6'h02)
    pulse_start;
    tick(8);
    `CHK(pwm_out, 6'h2a)
    `CHK(overlap_count, 8'h00)
    $display("test override done");
    wr(CPWM_REG_CTRL, 16'h0003);
    @(posedge clk_sys);
    gen_pwm <= 6'h29;
    comp_mode <= 1'b0;
    tick(3);
    `CHK(pwm_out, 6'h29)
    independent_mode_option_exp = {vals[5], vals[4], vals[3], vals[2], vals[1], vals[0]};
    `CHK(chan_compare, independent_mode_option_exp)
    $display("test independent mode done");
    end_of_test;
  end
endmodule
`default_nettype wire
